// ===== texture_mode_defines.vh
// Register offsets, field positions and reset values of the texture mode control block
`ifndef TEXTURE_MODE_DEFINES_VH
`define TEXTURE_MODE_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CONTROL_WORD   8'h00
`define OFS_LOD_CONFIG     8'h04
`define OFS_SIZE_CONFIG    8'h08
`define OFS_STATUS         8'h0c

// ****************************************
// Reset values
// ****************************************
`define RST_CONTROL_WORD   32'h0000_0000
`define RST_LOD_CONFIG     32'h0000_0000
`define RST_SIZE_CONFIG    8'h88

// ****************************************
// Control word fields
// ****************************************
`define BIT_PERSP          0
`define BIT_MIN_FILTER     1
`define BIT_MAG_FILTER     2
`define BIT_CLAMP_W        3
`define BIT_LOD_DITHER     4
`define BIT_NCC_SELECT     5
`define BIT_CLAMP_S        6
`define BIT_CLAMP_T        7
`define FMT_LSB            8
`define COLOR_CTL_LSB      12
`define ALPHA_CTL_LSB      21
`define BIT_TRILINEAR      30
`define BIT_SEQ_DOWNLOAD   31

// Combine control field offsets within a 9-bit group
`define CC_ZERO_OTHER      0
`define CC_SUB_LOCAL       1
`define CC_SEL_LSB         2
`define CC_REVERSE         5
`define CC_ADD_COLOR       6
`define CC_ADD_ALPHA       7
`define CC_INVERT          8

// Blend factor codes
`define SEL_ZERO           3'h0
`define SEL_LOCAL          3'h1
`define SEL_OTHER_ALPHA    3'h2
`define SEL_LOCAL_ALPHA    3'h3
`define SEL_LOD            3'h4
`define SEL_LOD_FRAC       3'h5

// LOD config fields (4.2 formats)
`define LOD_MIN_LSB        0
`define LOD_BIAS_LSB       12

`endif

// ===== coord_limit.v
// Clamps or wraps one integer texture coordinate into the texture extent
`timescale 1ns/1ns
module coord_limit #(
    parameter IW = 16
) (
    input  wire signed [IW-1:0] coord,
    input  wire [3:0]           size_log2,
    input  wire                 clamp_en,
    output reg  [7:0]           index
);
    wire [IW-1:0] size_mask = ({{(IW-1){1'b0}}, 1'b1} << size_log2) - {{(IW-1){1'b0}}, 1'b1};

    always @* begin
        if (clamp_en) begin
            if (coord < 0)
                index = 8'h00;
            else if ((coord & ~size_mask) != {IW{1'b0}})
                index = size_mask[7:0];
            else
                index = coord[7:0];
        end else begin
            index = coord[7:0] & size_mask[7:0];
        end
    end
endmodule // coord_limit

// ===== texel_expand.v
// Expands one raw texel of any format to 32-bit ARGB
`timescale 1ns/1ns
module texel_expand (
    input  wire [15:0] raw,
    input  wire [3:0]  format,
    input  wire [23:0] ncc_rgb,
    input  wire [23:0] palette_rgb,
    output reg  [31:0] argb
);
    wire [7:0] lo = raw[7:0];
    wire [7:0] hi = raw[15:8];

    // Narrow channels replicate their upper bits; alpha-less formats read opaque
    always @* begin
        case (format)
            4'h0: argb = {8'hff, lo[7:5], lo[7:5], lo[7:6], lo[4:2], lo[4:2], lo[4:3],
                          {4{lo[1:0]}}};
            4'h1: argb = {8'hff, ncc_rgb};
            4'h2: argb = {4{lo}};
            4'h3: argb = {8'hff, lo, lo, lo};
            4'h4: argb = {lo[7:4], lo[7:4], {3{lo[3:0], lo[3:0]}}};
            4'h5: argb = {8'hff, palette_rgb};
            4'h8: argb = {hi, lo[7:5], lo[7:5], lo[7:6], lo[4:2], lo[4:2], lo[4:3],
                          {4{lo[1:0]}}};
            4'h9: argb = {hi, ncc_rgb};
            4'ha: argb = {8'hff, raw[15:11], raw[15:13], raw[10:5], raw[10:9],
                          raw[4:0], raw[4:2]};
            4'hb: argb = {{8{raw[15]}}, raw[14:10], raw[14:12], raw[9:5], raw[9:7],
                          raw[4:0], raw[4:2]};
            4'hc: argb = {raw[15:12], raw[15:12], raw[11:8], raw[11:8],
                          raw[7:4], raw[7:4], raw[3:0], raw[3:0]};
            4'hd: argb = {hi, lo, lo, lo};
            4'he: argb = {hi, palette_rgb};
            default: argb = 32'h0000_0000;
        endcase
    end
endmodule // texel_expand

// ===== texture_mode_control.v
// Texture mode control: coordinate, filter, LOD, format and combine control
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "texture_mode_defines.vh"
module texture_mode_control #(
    parameter CW = 24,
    parameter FW = 8
) (
    input  wire                 mclk,
    input  wire                 reset,
    // Register port
    input  wire [7:0]           reg_addr,
    input  wire [31:0]          reg_wdata,
    input  wire                 reg_write,
    input  wire                 reg_read,
    output reg  [31:0]          reg_rdata,
    // Coordinate stage
    input  wire                 coord_valid,
    input  wire signed [CW-1:0] s_iter,
    input  wire signed [CW-1:0] t_iter,
    input  wire signed [CW-1:0] w_iter,
    input  wire [5:0]           lod_calc,
    output reg                  fetch_valid,
    output reg  [7:0]           fetch_s0,
    output reg  [7:0]           fetch_s1,
    output reg  [7:0]           fetch_t0,
    output reg  [7:0]           fetch_t1,
    output reg  [7:0]           fetch_frac_s,
    output reg  [7:0]           fetch_frac_t,
    output reg                  fetch_bilinear,
    output reg                  fetch_minify,
    output reg  [7:0]           fetch_lod,
    output reg                  trilinear_en,
    output wire [3:0]           texel_format,
    output wire                 ncc_table_sel,
    // Texel return and combine stage
    input  wire                 texel_valid,
    input  wire [63:0]          texel_raw,
    input  wire [95:0]          ncc_rgb,
    input  wire [95:0]          palette_rgb,
    input  wire [7:0]           texel_frac_s,
    input  wire [7:0]           texel_frac_t,
    input  wire [7:0]           texel_lod,
    input  wire [31:0]          other_argb,
    output reg                  out_valid,
    output reg  [31:0]          out_argb,
    // 8-bit download addressing
    input  wire [15:0]          download_index,
    output wire [16:0]          download_word_addr
);
    localparam [FW-1:0] ONE_FRAC = {FW{1'b0}};
    localparam          IW       = CW - FW;

    // ****************************************
    // Registers
    // ****************************************
    reg [31:0] texture_control_word;
    reg [31:0] lod_config;
    reg [7:0]  size_config;
    reg [15:0] texel_count;
    reg        last_minify;
    reg [1:0]  dither_phase;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            texture_control_word <= `RST_CONTROL_WORD;
            lod_config           <= `RST_LOD_CONFIG;
            size_config          <= `RST_SIZE_CONFIG;
        end else if (reg_write) begin
            // New settings reach coordinates accepted after this edge and texels returned after it
            case (reg_addr)
                `OFS_CONTROL_WORD: texture_control_word <= reg_wdata;
                `OFS_LOD_CONFIG:   lod_config           <= reg_wdata;
                `OFS_SIZE_CONFIG:  size_config          <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                `OFS_CONTROL_WORD: reg_rdata <= texture_control_word;
                `OFS_LOD_CONFIG:   reg_rdata <= lod_config;
                `OFS_SIZE_CONFIG:  reg_rdata <= {24'h00_0000, size_config};
                `OFS_STATUS:       reg_rdata <= {15'h0000, last_minify, texel_count};
                default:           reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Control fields
    // ****************************************
    wire       persp_correct_en = texture_control_word[`BIT_PERSP];
    wire       min_bilinear     = texture_control_word[`BIT_MIN_FILTER];
    wire       mag_bilinear     = texture_control_word[`BIT_MAG_FILTER];
    wire       clamp_w_en       = texture_control_word[`BIT_CLAMP_W];
    wire       lod_dither_en    = texture_control_word[`BIT_LOD_DITHER];
    wire       clamp_s_en       = texture_control_word[`BIT_CLAMP_S];
    wire       clamp_t_en       = texture_control_word[`BIT_CLAMP_T];
    wire [8:0] color_ctl        = texture_control_word[`COLOR_CTL_LSB +: 9];
    wire [8:0] alpha_ctl        = texture_control_word[`ALPHA_CTL_LSB +: 9];
    wire       seq_download     = texture_control_word[`BIT_SEQ_DOWNLOAD];

    // Reserved format codes behave as code zero
    function [3:0] legal_format;
        input [3:0] code;
        begin
            case (code)
                4'h6, 4'h7, 4'hf: legal_format = 4'h0;
                default:          legal_format = code;
            endcase
        end
    endfunction

    assign texel_format  = legal_format(texture_control_word[`FMT_LSB +: 4]);
    assign ncc_table_sel = texture_control_word[`BIT_NCC_SELECT];

    // Software on first-revision parts keeps this bit clear
    assign download_word_addr = seq_download ? {1'b0, download_index}
                                             : {download_index, 1'b0};

    // ****************************************
    // Coordinate projection
    // ****************************************
    // Combinational divide keeps one texel per cycle at the cost of a long path
    wire               w_negative = w_iter[CW-1];
    wire signed [CW+FW-1:0] s_wide = {{FW{s_iter[CW-1]}}, s_iter} <<< FW;
    wire signed [CW+FW-1:0] t_wide = {{FW{t_iter[CW-1]}}, t_iter} <<< FW;
    wire signed [CW+FW-1:0] w_wide = (w_iter == {CW{1'b0}}) ?
                                     {{(CW-1){1'b0}}, 1'b1, ONE_FRAC} :
                                     {{FW{w_iter[CW-1]}}, w_iter};
    wire signed [CW+FW-1:0] s_div  = s_wide / w_wide;
    wire signed [CW+FW-1:0] t_div  = t_wide / w_wide;

    reg signed [CW-1:0] s_proj;
    reg signed [CW-1:0] t_proj;
    always @* begin
        if (clamp_w_en && w_negative) begin
            s_proj = {CW{1'b0}};
            t_proj = {CW{1'b0}};
        end else if (persp_correct_en) begin
            s_proj = s_div[CW-1:0];
            t_proj = t_div[CW-1:0];
        end else begin
            s_proj = s_iter;
            t_proj = t_iter;
        end
    end

    // ****************************************
    // LOD and filter choice
    // ****************************************
    // LOD carried with three fraction bits so the dither average is exact
    wire [2:0]        dither_add = lod_dither_en ? {dither_phase, 1'b0} : 3'h0;
    wire signed [9:0] lod_sum    = $signed({2'b00, lod_calc, 1'b0})
                                 + $signed({{2{lod_config[`LOD_BIAS_LSB + 5]}},
                                            lod_config[`LOD_BIAS_LSB +: 6], 1'b0})
                                 + $signed({7'h00, dither_add});
    wire signed [9:0] lod_min    = $signed({2'b00, lod_config[`LOD_MIN_LSB +: 6], 1'b0});
    wire              minify     = (lod_sum >= lod_min);
    wire [7:0]        lod_clamp  = minify ? lod_sum[7:0] : lod_min[7:0];
    wire              bilinear   = minify ? min_bilinear : mag_bilinear;

    // ****************************************
    // Texel addressing
    // ****************************************
    wire signed [IW-1:0] s_int  = s_proj[CW-1:FW];
    wire signed [IW-1:0] t_int  = t_proj[CW-1:FW];
    wire [IW*4-1:0]      coords = {t_int + {{(IW-1){1'b0}}, 1'b1}, t_int,
                                   s_int + {{(IW-1){1'b0}}, 1'b1}, s_int};
    wire [31:0]          limited;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_limit
            coord_limit #(.IW(IW)) u_limit (
                .coord     (coords[gi*IW +: IW]),
                .size_log2 (gi < 2 ? size_config[3:0] : size_config[7:4]),
                .clamp_en  (gi < 2 ? clamp_s_en : clamp_t_en),
                .index     (limited[gi*8 +: 8])
            );
        end
    endgenerate

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            fetch_valid    <= 1'b0;
            fetch_s0       <= 8'h00;
            fetch_s1       <= 8'h00;
            fetch_t0       <= 8'h00;
            fetch_t1       <= 8'h00;
            fetch_frac_s   <= 8'h00;
            fetch_frac_t   <= 8'h00;
            fetch_bilinear <= 1'b0;
            fetch_minify   <= 1'b0;
            fetch_lod      <= 8'h00;
            trilinear_en   <= 1'b0;
            dither_phase   <= 2'h0;
            last_minify    <= 1'b0;
        end else begin
            fetch_valid <= coord_valid;
            if (coord_valid) begin
                fetch_s0       <= limited[7:0];
                fetch_t0       <= limited[23:16];
                // Point sampling repeats the single texel at weight zero
                fetch_s1       <= bilinear ? limited[15:8]  : limited[7:0];
                fetch_t1       <= bilinear ? limited[31:24] : limited[23:16];
                fetch_frac_s   <= bilinear ? s_proj[FW-1:FW-8] : 8'h00;
                fetch_frac_t   <= bilinear ? t_proj[FW-1:FW-8] : 8'h00;
                fetch_bilinear <= bilinear;
                fetch_minify   <= minify;
                fetch_lod      <= lod_clamp;
                trilinear_en   <= texture_control_word[`BIT_TRILINEAR];
                dither_phase   <= dither_phase + 2'h1;
                last_minify    <= minify;
            end
        end
    end

    // ****************************************
    // Texel expansion and bilinear blend
    // ****************************************
    wire [127:0] texel_argb;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_expand
            texel_expand u_expand (
                .raw         (texel_raw[gi*16 +: 16]),
                .format      (texel_format),
                .ncc_rgb     (ncc_rgb[gi*24 +: 24]),
                .palette_rgb (palette_rgb[gi*24 +: 24]),
                .argb        (texel_argb[gi*32 +: 32])
            );
        end
    endgenerate

    // Texel order: (s0,t0), (s1,t0), (s0,t1), (s1,t1)
    function [7:0] blend4;
        input [7:0] a, b, c, d, fs, ft;
        reg   [8:0]  ws, wt;
        reg   [16:0] top, bot;
        reg   [25:0] sum;
        begin
            ws     = 9'h100 - {1'b0, fs};
            wt     = 9'h100 - {1'b0, ft};
            top    = a * ws + b * fs;
            bot    = c * ws + d * fs;
            sum    = top * wt + bot * ft;
            blend4 = sum[23:16];
        end
    endfunction

    wire [31:0] filtered;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_blend
            assign filtered[gi*8 +: 8] = blend4(texel_argb[gi*8 +: 8],
                                                texel_argb[32 + gi*8 +: 8],
                                                texel_argb[64 + gi*8 +: 8],
                                                texel_argb[96 + gi*8 +: 8],
                                                texel_frac_s, texel_frac_t);
        end
    endgenerate

    // ****************************************
    // Combine units
    // ****************************************
    function [7:0] combine;
        input [8:0] ctl;
        input [7:0] other, own, other_a, local_a, lod, lod_frac;
        reg   [7:0]  factor;
        reg   [9:0]  diff;
        reg   [19:0] prod;
        reg   [9:0]  sum;
        begin
            case (ctl[`CC_SEL_LSB +: 3])
                `SEL_LOCAL:       factor = own;
                `SEL_OTHER_ALPHA: factor = other_a;
                `SEL_LOCAL_ALPHA: factor = local_a;
                `SEL_LOD:         factor = lod;
                `SEL_LOD_FRAC:    factor = lod_frac;
                default:          factor = 8'h00;
            endcase
            if (ctl[`CC_REVERSE])
                factor = ~factor;
            diff = (ctl[`CC_ZERO_OTHER] ? 10'h000 : {2'b00, other})
                 - (ctl[`CC_SUB_LOCAL] ? {2'b00, own} : 10'h000);
            prod = $signed(diff) * $signed({2'b00, factor} + 10'h001);
            sum  = prod[17:8]
                 + (ctl[`CC_ADD_COLOR] ? {2'b00, own} : 10'h000)
                 + (ctl[`CC_ADD_ALPHA] ? {2'b00, local_a} : 10'h000);
            if (sum[9])
                combine = 8'h00;
            else if (sum[8])
                combine = 8'hff;
            else
                combine = sum[7:0];
            if (ctl[`CC_INVERT])
                combine = ~combine;
        end
    endfunction

    wire [7:0]  lod_frac = {texel_lod[2:0], 5'h00};
    wire [31:0] combined;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_combine
            // Index 3 is alpha; the three colour lanes share one control group
            assign combined[gi*8 +: 8] = combine(gi == 3 ? alpha_ctl : color_ctl,
                                                 other_argb[gi*8 +: 8],
                                                 filtered[gi*8 +: 8],
                                                 other_argb[31:24], filtered[31:24],
                                                 texel_lod, lod_frac);
        end
    endgenerate

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            out_valid   <= 1'b0;
            out_argb    <= 32'h0000_0000;
            texel_count <= 16'h0000;
        end else begin
            out_valid <= texel_valid;
            if (texel_valid) begin
                out_argb    <= combined;
                texel_count <= texel_count + 16'h0001;
            end
        end
    end
endmodule // texture_mode_control

// ===== texture_mode_control_sva.sv
// Assertion checker for the texture mode control block
`timescale 1ns/1ns
module texture_mode_checker (
    input wire        mclk,
    input wire        reset,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_write,
    input wire        reg_read,
    input wire [31:0] reg_rdata,
    input wire        coord_valid,
    input wire        fetch_valid,
    input wire [7:0]  fetch_s0,
    input wire [7:0]  fetch_s1,
    input wire [7:0]  fetch_t0,
    input wire [7:0]  fetch_t1,
    input wire [7:0]  fetch_frac_s,
    input wire [7:0]  fetch_frac_t,
    input wire        fetch_bilinear,
    input wire        fetch_minify,
    input wire [3:0]  texel_format,
    input wire        ncc_table_sel,
    input wire        texel_valid,
    input wire        out_valid,
    input wire [15:0] download_index,
    input wire [16:0] download_word_addr
);
// Shadow of the control word, so the format, table select, download address and filter choice can be tied to what software wrote
reg [31:0] ctl;
always @(posedge mclk or posedge reset) begin
    if (reset) ctl <= 32'h0000_0000;
    else if (reg_write && reg_addr == 8'h00) ctl <= reg_wdata;
end
// ****************************************
// Properties
// ****************************************
default clocking @(posedge mclk); endclocking
default disable iff (reset);
property p_fetch; fetch_valid == $past(coord_valid); endproperty
a_fetch: assert property (p_fetch) else $error("fetch pulse misplaced");
property p_out; out_valid == $past(texel_valid); endproperty
a_out: assert property (p_out) else $error("result pulse misplaced");
property p_idle; !reg_read |=> reg_rdata == 32'h0000_0000; endproperty
a_idle: assert property (p_idle) else $error("read data not idle");
property p_rd; reg_read && reg_addr == 8'h00 |=> reg_rdata == $past(ctl); endproperty
a_rd: assert property (p_rd) else $error("control word readback wrong");
property p_ncc; ncc_table_sel == ctl[5]; endproperty
a_ncc: assert property (p_ncc) else $error("table select wrong");
property p_fmt; texel_format == ((ctl[11:9] == 3'h3 || ctl[11:8] == 4'hf) ? 4'h0 : ctl[11:8]);
endproperty
a_fmt: assert property (p_fmt) else $error("format code wrong");
property p_dl;
    download_word_addr == (ctl[31] ? {1'b0, download_index} : {download_index, 1'b0});
endproperty
a_dl: assert property (p_dl) else $error("download address wrong");
property p_point;
    fetch_valid && !fetch_bilinear |-> fetch_s1 == fetch_s0 && fetch_t1 == fetch_t0
        && fetch_frac_s == 8'h00 && fetch_frac_t == 8'h00;
endproperty
a_point: assert property (p_point) else $error("point fetch not single");
// Only judged when no write hit the accepting edge, so the word in use is unambiguous
property p_filt;
    fetch_valid && !$past(reg_write) |-> fetch_bilinear == (fetch_minify ? ctl[1] : ctl[2]);
endproperty
a_filt: assert property (p_filt) else $error("filter choice wrong");
cover property (fetch_valid && fetch_bilinear);
cover property (fetch_valid && !fetch_minify);
cover property (out_valid);
endmodule // texture_mode_checker
bind texture_mode_control texture_mode_checker chk_i (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .coord_valid(coord_valid), .fetch_valid(fetch_valid),
    .fetch_s0(fetch_s0), .fetch_s1(fetch_s1), .fetch_bilinear(fetch_bilinear),
    .fetch_t0(fetch_t0), .fetch_t1(fetch_t1),
    .fetch_frac_s(fetch_frac_s), .fetch_frac_t(fetch_frac_t),
    .fetch_minify(fetch_minify), .texel_format(texel_format), .ncc_table_sel(ncc_table_sel),
    .texel_valid(texel_valid), .out_valid(out_valid), .download_index(download_index),
    .download_word_addr(download_word_addr));

// ===== texture_mode_control_bench.sv
// Self-checking bench for the texture mode control block
`timescale 1ns/1ns
module texture_mode_control_bench;
reg         mclk = 1'b0, reset = 1'b1, rd_seen = 1'b0;
reg  [3:0]  st = 4'h0;
reg  [5:0]  lod_calc = 6'h00;
reg  [7:0]  reg_addr = 8'h00, texel_lod = 8'h00;
reg  [15:0] download_index = 16'h0000, fr = 16'h0000;
reg  [23:0] s_iter = '0, t_iter = '0, w_iter = '0, c = '0;
reg  [31:0] reg_wdata = '0, other_argb = '0, d, qr[$], qo[$], qf[$];
reg  [63:0] texel_raw = '0, x;
wire        fetch_valid, fetch_minify, out_valid, trilinear_en;
wire [7:0]  fetch_s0, fetch_t0, fetch_lod;
wire [31:0] reg_rdata, out_argb;
wire [31:0] fview = {6'h00, trilinear_en, fetch_lod, fetch_s0, fetch_t0, fetch_minify};
integer     seed = 38670, miscompares = 0, n_checks = 0, k;
texture_mode_control DUT (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(st[3]), .reg_read(st[2]), .reg_rdata(reg_rdata), .coord_valid(st[1]),
    .s_iter(s_iter), .t_iter(t_iter), .w_iter(w_iter), .lod_calc(lod_calc),
    .fetch_valid(fetch_valid), .fetch_s0(fetch_s0), .fetch_s1(), .fetch_t0(fetch_t0),
    .fetch_t1(), .fetch_frac_s(), .fetch_frac_t(), .fetch_bilinear(), .fetch_minify(fetch_minify),
    .fetch_lod(fetch_lod), .trilinear_en(trilinear_en), .texel_format(), .ncc_table_sel(),
    .texel_valid(st[0]), .texel_raw(texel_raw), .ncc_rgb({4{c}}), .palette_rgb({4{c}}),
    .texel_frac_s(fr[7:0]), .texel_frac_t(fr[15:8]), .texel_lod(texel_lod),
    .other_argb(other_argb), .out_valid(out_valid),
    .out_argb(out_argb), .download_index(download_index), .download_word_addr());
always #5 mclk = ~mclk;
task chk(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
        miscompares++;
        $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
endtask
task stop_test;
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
// Strobes travel as one vector so every step sets or drops all of them at once
task bus(input w, input r, input [7:0] a, input [31:0] dd);
    @(posedge mclk);
    st <= {w, r, 2'b00};
    {reg_addr, reg_wdata} <= {a, dd};
endtask
task rd(input [7:0] a, input [31:0] e);
    qr.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
endtask
task crd(input [23:0] s, input [23:0] t, input [23:0] w, input [5:0] l, input [25:0] e);
    @(posedge mclk);
    st <= 4'h2;
    {s_iter, t_iter, w_iter, lod_calc} <= {s, t, w, l};
    qf.push_back({6'h00, e});
endtask
// Texel index on a 16x16 texture: clamp into 0..15 or keep the low integer bits
function [7:0] lim(input [23:0] v, input cl);
    integer i;
    begin
        i = $signed(v) >>> 8;
        lim = cl ? (i < 0 ? 8'h00 : i > 15 ? 8'h0f : i[7:0]) : {4'h0, v[11:8]};
    end
endfunction
function [31:0] ex(input [3:0] f, input [15:0] x, input [23:0] c);
    reg [7:0] v, h;
    begin
        v = x[7:0];
        h = x[15:8];
        ex = {8'hff, v[7:5], v[7:5], v[7:6], v[4:2], v[4:2], v[4:3], {4{v[1:0]}}};
        case (f)
            4'h1, 4'h5: ex = {8'hff, c};
            4'h2: ex = {4{v}};
            4'h3: ex = {8'hff, v, v, v};
            4'h4: ex = {{2{v[7:4]}}, {6{v[3:0]}}};
            4'h8: ex[31:24] = h;
            4'h9, 4'he: ex = {h, c};
            4'ha: ex = {8'hff, x[15:11], x[15:13], x[10:5], x[10:9], x[4:0], x[4:2]};
            4'hb: ex = {{8{x[15]}}, x[14:10], x[14:12], x[9:5], x[9:7], x[4:0], x[4:2]};
            4'hc: ex = {{2{x[15:12]}}, {2{x[11:8]}}, {2{x[7:4]}}, {2{x[3:0]}}};
            4'hd: ex = {h, v, v, v};
        endcase
    end
endfunction
always @(posedge mclk) begin
    if (rd_seen) chk(reg_rdata, qr.pop_front());
    if (fetch_valid === 1'b1) chk(fview, qf.pop_front());
    if (out_valid === 1'b1) chk(out_argb, qo.pop_front());
    rd_seen = st[2];
end
initial begin
    #20000;
    miscompares++;
    stop_test;
end
// ****************************************
// Stimulus
// ****************************************
initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    rd(8'h00, 32'h0000_0000);
    rd(8'h08, 32'h0000_0088);
    d = $random(seed);
    bus(1'b1, 1'b0, 8'h00, d);
    rd(8'h00, d);
    rd(8'h10, 32'h0000_0000);
    bus(1'b1, 1'b0, 8'h08, 32'h0000_0044);
    bus(1'b1, 1'b0, 8'h04, 32'h0000_0010);
    for (k = 0; k < 4; k++) begin
        d = $random(seed) & 32'h4000_00ce;
        bus(1'b1, 1'b0, 8'h00, d);
        repeat (8) begin
            x = {$random(seed), $random(seed)};
            crd(x[23:0], x[47:24], {x[63:56], 16'h0100}, x[53:48],
                {d[30], (x[53:52] != 2'b00) ? {1'b0, x[53:48], 1'b0} : 8'h20,
                 (d[3] && x[63]) ? 16'h0000 : {lim(x[23:0], d[6]), lim(x[47:24], d[7])},
                 x[53:52] != 2'b00});
        end
    end
    bus(1'b1, 1'b0, 8'h00, 32'h0000_0001);
    crd(24'h00_0800, 24'h00_1000, 24'h00_0200, 6'h02, 26'h040_0810);
    for (k = 0; k < 16; k++) begin
        // Odd passes also set both invert bits, so every lane must come out flipped
        d = 32'h0824_1000 | (k << 8) | ($random(seed) & 32'h8000_0020)
          | {2'b00, k[0], 8'h00, k[0], 20'h0_0000};
        bus(1'b1, 1'b0, 8'h00, d);
        repeat (2) begin
            x = {$random(seed), $random(seed)};
            @(posedge mclk);
            st <= 4'h1;
            {c, other_argb, texel_lod, download_index} <=
                {x[55:32], ~x[31:0], x[15:8], x[47:32]};
            // Equal texels under random weights must blend back to that texel
            texel_raw <= x[63] ? {4{x[15:0]}} : x;
            fr <= x[63] ? x[47:32] : 16'h0000;
            qo.push_back(ex(k[3:0], x[15:0], x[55:32])
                         ^ {32{k[0]}});
        end
    end
    rd(8'h0c, 32'h0000_0020);
    bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    chk(qr.size() + qo.size() + qf.size(), 0);
    stop_test;
end
endmodule // texture_mode_control_bench
